//--- design/mss_pkg.sv
// Shared constants, modes and carriers of the multiply-accumulate and store datapath
package mss_pkg;

    localparam int DATA_W   = 16;
    localparam int MUL_W    = 17;
    localparam int PRODX_W  = 34;
    localparam int PROD_W   = 32;
    localparam int ACC_W    = 40;
    localparam int SUM_W    = 41;
    localparam int SHX_W    = 72;
    localparam int NACC     = 4;
    localparam int SEL_W    = 2;
    localparam int CNT6_W   = 6;
    localparam int AMT_W    = 7;
    localparam int STORE_HI = 31;
    localparam int STORE_LO = 16;
    localparam int RND_LO   = 15;
    localparam int NARROW_SIGN = 31;

    // Product saturation
    localparam logic signed [MUL_W-1:0]  MUL_MIN  = 17'h18000;
    localparam logic        [PROD_W-1:0] PROD_SAT = 32'h7FFFFFFF;

    // Rounding
    localparam logic [SUM_W-1:0] RND_ADD  = 41'h00000008000;
    localparam logic [SUM_W-1:0] RND_MASK = 41'h1FFFFFF0000;
    localparam logic [DATA_W-1:0] RND_TIE = 16'h8000;

    // Accumulator saturation limits
    localparam logic [ACC_W-1:0] ACC_POS40 = 40'h7FFFFFFFFF;
    localparam logic [ACC_W-1:0] ACC_NEG40 = 40'h8000000000;
    localparam logic [ACC_W-1:0] ACC_POS32 = 40'h007FFFFFFF;
    localparam logic [ACC_W-1:0] ACC_NEG32 = 40'hFF80000000;

    // Shift count limits
    localparam logic [DATA_W-1:0] SHIFT_MAX16 = 16'h001F;
    localparam logic [DATA_W-1:0] SHIFT_MIN16 = 16'hFFE0;
    localparam logic [CNT6_W-1:0] WRAP_LO     = 6'h20;
    localparam logic [CNT6_W-1:0] WRAP_HI     = 6'h2F;
    localparam logic [CNT6_W-1:0] WRAP_ADD    = 6'h10;

    // Store saturation limits
    localparam logic [SHX_W-1:0] SAT_POS72 = 72'h00000000007FFFFFFF;
    localparam logic [SHX_W-1:0] SAT_NEG72 = 72'hFFFFFFFFFF80000000;
    localparam logic [SHX_W-1:0] SAT_UNS72 = 72'h0000000000FFFFFFFF;
    localparam logic [PROD_W-1:0] SAT32_POS = 32'h7FFFFFFF;
    localparam logic [PROD_W-1:0] SAT32_NEG = 32'h80000000;
    localparam logic [PROD_W-1:0] SAT32_UNS = 32'hFFFFFFFF;

    typedef enum logic [2:0] {
        MSS_OP_MAC_STORE = 3'b001,
        MSS_OP_MAS_MEM   = 3'b010,
        MSS_OP_MAS_COEF  = 3'b100
    } mss_op_t;

    typedef struct packed {
        logic fractional_mode;
        logic product_saturation_mode;
        logic rounding_method;
        logic wide_overflow_mode;
        logic accumulator_saturation_enable;
        logic sign_extension_mode;
        logic store_saturation_mode;
        logic legacy_compat_mode;
    } mss_mode_t;

    typedef struct packed {
        logic             valid;
        mss_op_t          op;
        logic [SEL_W-1:0] dest_sel;
        logic             round_req;
        logic             local_wide;
        logic             uns_a;
        logic             uns_b;
        logic             t3_copy;
        logic             store_sat_req;
        logic             store_uns_req;
    } mss_req_t;

endpackage

//--- design/mss_datapath.sv
// Multiply-accumulate / multiply-subtract datapath with parallel shifted accumulator store
module mss_datapath
    import mss_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire mss_mode_t         mode,
    input  wire mss_req_t          req,
    input  wire logic [ACC_W-1:0]  src_acc,
    input  wire logic [ACC_W-1:0]  store_acc,
    input  wire logic [DATA_W-1:0] temp_operand,
    input  wire logic [DATA_W-1:0] mem_x,
    input  wire logic [DATA_W-1:0] mem_y,
    input  wire logic [DATA_W-1:0] shift_count_register,
    input  wire logic [NACC-1:0]   ovf_clear,
    output logic                   result_valid,
    output logic [SEL_W-1:0]       result_sel,
    output logic [ACC_W-1:0]       dest_acc,
    output logic                   acc_overflow,
    output logic [NACC-1:0]        dest_overflow_flag,
    output logic                   store_valid,
    output logic [DATA_W-1:0]      store_data,
    output logic                   t3_load,
    output logic [DATA_W-1:0]      third_temp_register
);

    logic                    result_valid_reg;
    logic [SEL_W-1:0]        result_sel_reg;
    logic [ACC_W-1:0]        dest_acc_reg;
    logic                    acc_overflow_reg;
    logic [NACC-1:0]         dest_overflow_flag_reg;
    logic [NACC-1:0]         dest_overflow_flag_next;
    logic                    store_valid_reg;
    logic [DATA_W-1:0]       store_data_reg;
    logic                    t3_load_reg;
    logic [DATA_W-1:0]       third_temp_reg;

    logic signed [MUL_W-1:0]   mul_a;
    logic signed [MUL_W-1:0]   mul_b;
    logic signed [PRODX_W-1:0] prod_raw;
    logic        [PRODX_W-1:0] prod_shifted;
    logic                      prod_sat_hit;
    logic        [PROD_W-1:0]  prod32;
    logic        [ACC_W-1:0]   prod40;
    logic                      is_sub;
    logic                      wide_eff;
    logic        [SUM_W-1:0]   sum41;
    logic                      rnd_tie_hold;
    logic        [SUM_W-1:0]   rnd41;
    logic                      ovf_c;
    logic        [ACC_W-1:0]   acc_next;

    logic        [DATA_W-1:0]  clamp16;
    logic        [CNT6_W-1:0]  cnt6;
    logic signed [AMT_W-1:0]   sh_amt;
    logic        [AMT_W-1:0]   sh_mag;
    logic                      sat_eff;
    logic                      uns_eff;
    logic signed [SHX_W-1:0]   ext72;
    logic signed [SHX_W-1:0]   shifted;
    logic        [PROD_W-1:0]  store32;

    // Memory operand extension for the dual-memory subtract form
    function automatic logic signed [MUL_W-1:0] ext17(
        input logic [DATA_W-1:0] d,
        input logic              uns,
        input logic              sx
    );
        ext17 = (uns || !sx) ? {1'b0, d} : {d[DATA_W-1], d};
    endfunction

    // Multiplier operand selection
    always_comb begin
        mul_a  = {temp_operand[DATA_W-1], temp_operand};
        mul_b  = {mem_x[DATA_W-1], mem_x};
        is_sub = 1'b0;
        unique case (req.op)
            MSS_OP_MAC_STORE: begin
                mul_a  = {temp_operand[DATA_W-1], temp_operand};
                mul_b  = {mem_x[DATA_W-1], mem_x};
                is_sub = 1'b0;
            end
            MSS_OP_MAS_MEM: begin
                mul_a  = ext17(mem_x, req.uns_a, mode.sign_extension_mode);
                mul_b  = ext17(mem_y, req.uns_b, mode.sign_extension_mode);
                is_sub = 1'b1;
            end
            MSS_OP_MAS_COEF: begin
                mul_a  = {mem_x[DATA_W-1], mem_x};
                mul_b  = {mem_y[DATA_W-1], mem_y};
                is_sub = 1'b1;
            end
            default: begin
                mul_a  = {temp_operand[DATA_W-1], temp_operand};
                mul_b  = {mem_x[DATA_W-1], mem_x};
                is_sub = 1'b0;
            end
        endcase
    end

    // Product, fractional doubling and product saturation
    always_comb begin
        prod_raw     = mul_a * mul_b;
        prod_shifted = mode.fractional_mode ? {prod_raw[PRODX_W-2:0], 1'b0}
                                            : prod_raw;
        // Of sign-extended operands, only min-times-min can leave the signed 32-bit range here
        prod_sat_hit = mode.product_saturation_mode && mode.fractional_mode
                       && (mul_a == MUL_MIN) && (mul_b == MUL_MIN);
        prod32       = prod_sat_hit ? PROD_SAT : prod_shifted[PROD_W-1:0];
        prod40       = {{(ACC_W-PROD_W){prod32[PROD_W-1]}}, prod32};
    end

    // Accumulate, round, overflow check and saturation
    always_comb begin
        wide_eff = mode.wide_overflow_mode || req.local_wide;
        if (is_sub) begin
            sum41 = {src_acc[ACC_W-1], src_acc} - {prod40[ACC_W-1], prod40};
        end else begin
            sum41 = {src_acc[ACC_W-1], src_acc} + {prod40[ACC_W-1], prod40};
        end
        // Method one rounds ties to even; method zero always adds half an LSB
        rnd_tie_hold = mode.rounding_method && (sum41[DATA_W-1:0] == RND_TIE)
                       && !sum41[STORE_LO];
        if (req.round_req) begin
            rnd41 = (rnd_tie_hold ? sum41 : (sum41 + RND_ADD)) & RND_MASK;
        end else begin
            rnd41 = sum41;
        end
        if (wide_eff) begin
            ovf_c = rnd41[SUM_W-1] != rnd41[ACC_W-1];
        end else begin
            ovf_c = !((&rnd41[SUM_W-1:NARROW_SIGN]) || !(|rnd41[SUM_W-1:NARROW_SIGN]));
        end
        acc_next = rnd41[ACC_W-1:0];
        if (ovf_c && mode.accumulator_saturation_enable) begin
            if (wide_eff) begin
                acc_next = rnd41[SUM_W-1] ? ACC_NEG40 : ACC_POS40;
            end else begin
                acc_next = rnd41[SUM_W-1] ? ACC_NEG32 : ACC_POS32;
            end
        end
    end

    // Shift count: clamp, or six-bit legacy count with modulo wrap
    always_comb begin
        if ($signed(shift_count_register) > $signed(SHIFT_MAX16)) begin
            clamp16 = SHIFT_MAX16;
        end else if ($signed(shift_count_register) < $signed(SHIFT_MIN16)) begin
            clamp16 = SHIFT_MIN16;
        end else begin
            clamp16 = shift_count_register;
        end
        cnt6 = shift_count_register[CNT6_W-1:0];
        if (cnt6 >= WRAP_LO && cnt6 <= WRAP_HI) begin
            cnt6 = CNT6_W'(cnt6 + WRAP_ADD);
        end
        if (mode.legacy_compat_mode) begin
            sh_amt = {cnt6[CNT6_W-1], cnt6};
        end else begin
            sh_amt = clamp16[AMT_W-1:0];
        end
        sh_mag = sh_amt[AMT_W-1] ? AMT_W'(-sh_amt) : sh_amt;
    end

    // Store path shifter and store saturation
    always_comb begin
        sat_eff = req.store_sat_req;
        uns_eff = req.store_uns_req;
        if (mode.legacy_compat_mode && mode.store_saturation_mode) begin
            sat_eff = 1'b1;
            uns_eff = !mode.sign_extension_mode;
        end
        // Value sampled from the store operand port, never from the update path
        if (uns_eff || !mode.sign_extension_mode) begin
            ext72 = {{(SHX_W-ACC_W){1'b0}}, store_acc};
        end else begin
            ext72 = {{(SHX_W-ACC_W){store_acc[ACC_W-1]}}, store_acc};
        end
        shifted = sh_amt[AMT_W-1] ? (ext72 >>> sh_mag) : (ext72 <<< sh_mag);
        store32 = shifted[PROD_W-1:0];
        if (sat_eff) begin
            if (uns_eff) begin
                if (shifted > $signed(SAT_UNS72)) begin
                    store32 = SAT32_UNS;
                end
            end else if (shifted > $signed(SAT_POS72)) begin
                store32 = SAT32_POS;
            end else if (shifted < $signed(SAT_NEG72)) begin
                store32 = SAT32_NEG;
            end
        end
    end

    // Destination accumulator result
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            result_valid_reg <= 1'b0;
            result_sel_reg   <= '0;
            dest_acc_reg     <= '0;
            acc_overflow_reg <= 1'b0;
        end else begin
            result_valid_reg <= req.valid;
            acc_overflow_reg <= req.valid && ovf_c;
            if (req.valid) begin
                result_sel_reg <= req.dest_sel;
                dest_acc_reg   <= acc_next;
            end
        end
    end

    // Sticky overflow flags; a new overflow wins over a same-cycle clear
    always_comb begin
        dest_overflow_flag_next = dest_overflow_flag_reg & ~ovf_clear;
        if (req.valid && ovf_c) begin
            dest_overflow_flag_next[req.dest_sel] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dest_overflow_flag_reg <= '0;
        end else begin
            dest_overflow_flag_reg <= dest_overflow_flag_next;
        end
    end

    // Parallel store of the shifted high half
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            store_valid_reg <= 1'b0;
            store_data_reg  <= '0;
        end else begin
            store_valid_reg <= req.valid && (req.op == MSS_OP_MAC_STORE);
            if (req.valid && (req.op == MSS_OP_MAC_STORE)) begin
                store_data_reg <= store32[STORE_HI:STORE_LO];
            end
        end
    end

    // Third temporary register copy
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            t3_load_reg    <= 1'b0;
            third_temp_reg <= '0;
        end else begin
            t3_load_reg <= req.valid && req.t3_copy;
            if (req.valid && req.t3_copy) begin
                third_temp_reg <= mem_x;
            end
        end
    end

    assign result_valid        = result_valid_reg;
    assign result_sel          = result_sel_reg;
    assign dest_acc            = dest_acc_reg;
    assign acc_overflow        = acc_overflow_reg;
    assign dest_overflow_flag  = dest_overflow_flag_reg;
    assign store_valid         = store_valid_reg;
    assign store_data          = store_data_reg;
    assign t3_load             = t3_load_reg;
    assign third_temp_register = third_temp_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_frac_even_lsb: assert property (
        (mode.fractional_mode && !prod_sat_hit) |-> (prod32[0] == 1'b0))
        else $error("fractional product not doubled");

    a_prod_sat_val: assert property (
        prod_sat_hit |-> (prod32 == PROD_SAT))
        else $error("product saturation value wrong");

    a_mac_sum_out: assert property (
        (req.valid && !is_sub && !req.round_req && !ovf_c)
        |=> (dest_acc_reg == $past(src_acc) + $past(prod40)))
        else $error("accumulate result wrong");

    a_mas_diff_out: assert property (
        (req.valid && is_sub && !req.round_req && !ovf_c)
        |=> (dest_acc_reg == $past(src_acc) - $past(prod40)))
        else $error("subtract result wrong");

    a_round_low_zero: assert property (
        (req.valid && req.round_req && !ovf_c) |=> (dest_acc_reg[RND_LO:0] == '0))
        else $error("rounded result has low bits set");

    a_ovf_flag_set: assert property (
        (req.valid && ovf_c) |=> (acc_overflow_reg && dest_overflow_flag_reg[result_sel_reg]))
        else $error("overflow flag not set");

    a_acc_sat_wide: assert property (
        (req.valid && ovf_c && wide_eff && mode.accumulator_saturation_enable)
        |=> (dest_acc_reg == ACC_POS40 || dest_acc_reg == ACC_NEG40))
        else $error("wide saturation value wrong");

    a_t3_copy_val: assert property (
        (req.valid && req.t3_copy) |=> (t3_load_reg && third_temp_reg == $past(mem_x)))
        else $error("third temp copy wrong");

    a_store_hi_half: assert property (
        (req.valid && req.op == MSS_OP_MAC_STORE && !sat_eff)
        |=> (store_valid_reg && store_data_reg == $past(shifted[STORE_HI:STORE_LO])))
        else $error("stored high half wrong");

    a_shift_clamp_hi: assert property (
        (!mode.legacy_compat_mode && $signed(shift_count_register) > $signed(SHIFT_MAX16))
        |-> (sh_amt == AMT_W'(SHIFT_MAX16)))
        else $error("shift count not clamped");

    a_legacy_wrap: assert property (
        (mode.legacy_compat_mode && shift_count_register[CNT6_W-1:0] >= WRAP_LO
         && shift_count_register[CNT6_W-1:0] <= WRAP_HI)
        |-> (sh_amt < 0 && sh_amt >= -AMT_W'(WRAP_ADD)))
        else $error("legacy shift count not wrapped");

    a_legacy_force: assert property (
        (mode.legacy_compat_mode && mode.store_saturation_mode && !mode.sign_extension_mode)
        |-> (sat_eff && uns_eff))
        else $error("legacy store forcing missing");

endmodule

//--- sim/mss_core_model.sv
// Behavioural model of the core side: accumulator file, coefficient table and data memory
module mss_core_model
    import mss_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire logic              result_valid,
    input  wire logic [SEL_W-1:0]  result_sel,
    input  wire logic [ACC_W-1:0]  dest_acc,
    input  wire logic              store_valid,
    input  wire logic [DATA_W-1:0] store_data,
    input  wire logic [SEL_W-1:0]  rd_sel,
    output logic      [ACC_W-1:0]  acc_rd,
    output logic      [DATA_W-1:0] coef_word,
    output logic      [DATA_W-1:0] mem_word
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [ACC_W-1:0]  acc_file [NACC];
    logic [DATA_W-1:0] coef_mem [NACC];

    // Read port shows the value before any write-back landing on the same edge
    assign acc_rd = acc_file[rd_sel];
    // Coefficients are served from this internal table only; no external path exists
    assign coef_word = coef_mem[rd_sel];

    initial begin
        foreach (coef_mem[i]) begin
            coef_mem[i] = 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            foreach (acc_file[i]) begin
                acc_file[i] <= 40'h0000000000;
            end
        end else if (result_valid) begin
            acc_file[result_sel] <= dest_acc;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mem_word <= 16'h0000;
        end else if (store_valid) begin
            mem_word <= store_data;
        end
    end
endmodule

//--- sim/testbench.sv
// Self-checking bench of the multiply-accumulate and store datapath
module testbench;
    import mss_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int HALF = 25;
    localparam mss_op_t MAC = MSS_OP_MAC_STORE;
    localparam mss_op_t MSM = MSS_OP_MAS_MEM;
    localparam mss_op_t MSC = MSS_OP_MAS_COEF;
    localparam logic [DATA_W-1:0] Z16 = 16'h0000;
    localparam logic [ACC_W-1:0]  Z40 = 40'h0000000000;

    typedef struct packed {
        mss_mode_t         md;
        mss_req_t          rq;
        logic [ACC_W-1:0]  src;
        logic [ACC_W-1:0]  sacc;
        logic [DATA_W-1:0] tmp;
        logic [DATA_W-1:0] mx;
        logic [DATA_W-1:0] my;
        logic [DATA_W-1:0] cnt;
        logic [ACC_W-1:0]  eacc;
        logic [DATA_W-1:0] est;
        logic              eov;
    } mss_row_t;

    logic clk_sys, srst, result_valid, acc_overflow, store_valid, t3_load;
    mss_mode_t         mode;
    mss_req_t          req;
    logic [ACC_W-1:0]  src_acc, store_acc, dest_acc, acc_rd;
    logic [DATA_W-1:0] temp_operand, mem_x, mem_y, shift_count_register;
    logic [DATA_W-1:0] store_data, third_temp_register, coef_word, mem_word;
    logic [NACC-1:0]   ovf_clear, dest_overflow_flag;
    logic [SEL_W-1:0]  result_sel, rd_sel;
    int                mismatches = 0;
    int                checks = 0;
    mss_row_t          rows[$];
    mss_row_t          h;

    mss_datapath uut (.clk_sys(clk_sys), .srst(srst), .mode(mode), .req(req),
        .src_acc(src_acc), .store_acc(store_acc), .temp_operand(temp_operand),
        .mem_x(mem_x), .mem_y(mem_y), .shift_count_register(shift_count_register),
        .ovf_clear(ovf_clear), .result_valid(result_valid), .result_sel(result_sel),
        .dest_acc(dest_acc), .acc_overflow(acc_overflow),
        .dest_overflow_flag(dest_overflow_flag), .store_valid(store_valid),
        .store_data(store_data), .t3_load(t3_load),
        .third_temp_register(third_temp_register));

    mss_core_model u_core (.clk_sys(clk_sys), .srst(srst), .result_valid(result_valid),
        .result_sel(result_sel), .dest_acc(dest_acc), .store_valid(store_valid),
        .store_data(store_data), .rd_sel(rd_sel), .acc_rd(acc_rd),
        .coef_word(coef_word), .mem_word(mem_word));

    function automatic mss_req_t mkreq(input mss_op_t op, input logic [1:0] sel,
                                       input logic [6:0] f);
        return mss_req_t'({1'b1, op, sel, f});
    endfunction

    task automatic check(input logic [ACC_W-1:0] seen, input logic [ACC_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic drive_row(input mss_row_t r);
        mode <= r.md;
        req <= r.rq;
        src_acc <= r.src;
        store_acc <= r.sacc;
        temp_operand <= r.tmp;
        mem_x <= r.mx;
        mem_y <= r.my;
        shift_count_register <= r.cnt;
    endtask

    task automatic check_row(input mss_row_t r);
        check(result_valid, 1'b1);
        check(result_sel, r.rq.dest_sel);
        check(dest_acc, r.eacc);
        check(acc_overflow, r.eov);
        check(store_valid, r.rq.op == MAC);
        if (r.rq.op == MAC) begin
            check(store_data, r.est);
        end
        check(t3_load, r.rq.t3_copy);
        if (r.rq.t3_copy) begin
            check(third_temp_register, r.mx);
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #(HALF) clk_sys = ~clk_sys;
    end

    // Generous bound; the whole sequence needs well under a hundred cycles
    initial begin
        #(HALF * 2 * 3000);
        mismatches++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        give_verdict();
    end

    initial begin
        srst = 1'b1;
        mode = '0;
        req = '0;
        src_acc = Z40;
        store_acc = Z40;
        temp_operand = Z16;
        mem_x = Z16;
        mem_y = Z16;
        shift_count_register = Z16;
        ovf_clear = 4'h0;
        rd_sel = 2'h1;
        rows.push_back('{8'h04, mkreq(MAC, 2'h0, 7'h04), 40'h10, 40'h0000123400,
            16'h0003, 16'h0004, Z16, 16'h0004, 40'h1C, 16'h0123, 1'b0});
        rows.push_back('{8'h84, mkreq(MAC, 2'h1, 7'h00), Z40, 40'h0012345678,
            16'h4000, 16'h4000, Z16, 16'hFFF8, 40'h0020000000, 16'h0012, 1'b0});
        rows.push_back('{8'h04, mkreq(MAC, 2'h2, 7'h00), Z40, 40'h0000000001,
            Z16, Z16, Z16, 16'h0040, Z40, 16'h8000, 1'b0});
        rows.push_back('{8'h05, mkreq(MAC, 2'h3, 7'h00), Z40, 40'h1234000000,
            Z16, Z16, Z16, 16'h0060, Z40, 16'h0012, 1'b0});
        rows.push_back('{8'h00, mkreq(MAC, 2'h0, 7'h00), Z40, 40'hFF00000000,
            Z16, Z16, Z16, 16'hFFF0, Z40, 16'h00FF, 1'b0});
        rows.push_back('{8'h04, mkreq(MAC, 2'h0, 7'h00), Z40, 40'hFF00000000,
            Z16, Z16, Z16, 16'hFFF0, Z40, 16'hFFFF, 1'b0});
        rows.push_back('{8'h03, mkreq(MAC, 2'h0, 7'h00), Z40, 40'h0100000000,
            Z16, Z16, Z16, Z16, Z40, 16'hFFFF, 1'b0});
        rows.push_back('{8'h07, mkreq(MAC, 2'h0, 7'h01), Z40, 40'h0100000000,
            Z16, Z16, Z16, Z16, Z40, 16'h7FFF, 1'b0});
        rows.push_back('{8'h04, mkreq(MAC, 2'h0, 7'h02), Z40, 40'hF000000000,
            Z16, Z16, Z16, Z16, Z40, 16'h8000, 1'b0});
        rows.push_back('{8'h04, mkreq(MSM, 2'h3, 7'h14), 40'h0000100000, Z40,
            Z16, 16'hFFFF, 16'h0002, Z16, 40'h00000E0002, Z16, 1'b0});
        rows.push_back('{8'h04, mkreq(MSM, 2'h3, 7'h00), 40'h0000100000, Z40,
            Z16, 16'hFFFF, 16'h0002, Z16, 40'h0000100002, Z16, 1'b0});
        rows.push_back('{8'h00, mkreq(MSM, 2'h3, 7'h00), 40'h0000100000, Z40,
            Z16, 16'hFFFF, 16'h0002, Z16, 40'h00000E0002, Z16, 1'b0});
        rows.push_back('{8'h04, mkreq(MSC, 2'h2, 7'h00), 40'h007FFFFFFF, Z40,
            Z16, 16'hFFFF, 16'h0001, Z16, 40'h0080000000, Z16, 1'b1});
        rows.push_back('{8'h0C, mkreq(MSC, 2'h2, 7'h00), 40'h007FFFFFFF, Z40,
            Z16, 16'hFFFF, 16'h0001, Z16, 40'h007FFFFFFF, Z16, 1'b1});
        rows.push_back('{8'h14, mkreq(MSC, 2'h2, 7'h00), 40'h007FFFFFFF, Z40,
            Z16, 16'hFFFF, 16'h0001, Z16, 40'h0080000000, Z16, 1'b0});
        rows.push_back('{8'h04, mkreq(MSC, 2'h2, 7'h20), 40'h007FFFFFFF, Z40,
            Z16, 16'hFFFF, 16'h0001, Z16, 40'h0080000000, Z16, 1'b0});
        rows.push_back('{8'h1C, mkreq(MAC, 2'h0, 7'h00), 40'h7FFFFFFFFF, Z40,
            16'h0001, 16'h0001, Z16, Z16, 40'h7FFFFFFFFF, Z16, 1'b1});
        rows.push_back('{8'h04, mkreq(MAC, 2'h1, 7'h40), 40'h0000028000, Z40,
            Z16, Z16, Z16, Z16, 40'h0000030000, Z16, 1'b0});
        rows.push_back('{8'h24, mkreq(MAC, 2'h1, 7'h40), 40'h0000028000, Z40,
            Z16, Z16, Z16, Z16, 40'h0000020000, Z16, 1'b0});
        rows.push_back('{8'hC4, mkreq(MAC, 2'h1, 7'h00), Z40, Z40,
            16'h8000, 16'h8000, Z16, Z16, 40'h007FFFFFFF, Z16, 1'b0});
        rows.push_back('{8'h04, mkreq(MAC, 2'h0, 7'h03), Z40, 40'h0100000000,
            Z16, Z16, Z16, Z16, Z40, 16'hFFFF, 1'b0});
        rows.push_back('{8'h04, mkreq(MSM, 2'h3, 7'h08), 40'h0000100000, Z40,
            Z16, 16'h0002, 16'hFFFF, Z16, 40'h00000E0002, Z16, 1'b0});
        rows.push_back('{8'h04, mkreq(MAC, 2'h0, 7'h00), Z40, 40'h8000000000,
            Z16, Z16, Z16, 16'hFF00, Z40, 16'hFFFF, 1'b0});
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        #1;
        check(dest_acc, Z40);
        check(dest_overflow_flag, 4'h0);
        check(store_data, Z16);
        check(third_temp_register, Z16);
        check(result_valid, 1'b0);
        $display("reset test done");
        // Rows issue back to back, one per cycle
        for (int i = 0; i <= rows.size(); i++) begin
            @(posedge clk_sys);
            if (i < rows.size()) drive_row(rows[i]);
            else req.valid <= 1'b0;
            #1;
            if (i > 0) check_row(rows[i-1]);
        end
        check(dest_overflow_flag, 4'h5);
        $display("table test done");
        @(posedge clk_sys);
        ovf_clear <= 4'h4;
        @(posedge clk_sys);
        ovf_clear <= 4'h0;
        #1;
        check(dest_overflow_flag, 4'h1);
        h = '{8'h04, mkreq(MSC, 2'h1, 7'h00), 40'h007FFFFFFF, Z40,
            Z16, 16'hFFFF, Z16, Z16, 40'h0080000000, Z16, 1'b1};
        @(posedge clk_sys);
        h.my = coef_word;
        drive_row(h);
        ovf_clear <= 4'h3;
        @(posedge clk_sys);
        req.valid <= 1'b0;
        ovf_clear <= 4'h0;
        #1;
        check_row(h);
        check(dest_overflow_flag, 4'h2);
        @(posedge clk_sys);
        #1;
        check(acc_overflow, 1'b0);
        check(dest_overflow_flag, 4'h2);
        $display("flag test done");
        h = '{8'h04, mkreq(MAC, 2'h1, 7'h00), 40'h0012340000, Z40,
            Z16, Z16, Z16, Z16, 40'h0012340000, Z16, 1'b0};
        @(posedge clk_sys);
        drive_row(h);
        @(posedge clk_sys);
        req.valid <= 1'b0;
        #1;
        check_row(h);
        repeat (2) @(posedge clk_sys);
        h.tmp = 16'h0100;
        h.mx = 16'h0100;
        h.eacc = 40'h0012350000;
        h.est = 16'h1234;
        check(acc_rd, 40'h0012340000);
        h.src = acc_rd;
        h.sacc = acc_rd;
        drive_row(h);
        @(posedge clk_sys);
        req.valid <= 1'b0;
        #1;
        check_row(h);
        @(posedge clk_sys);
        #1;
        check(mem_word, 16'h1234);
        check(acc_rd, 40'h0012350000);
        $display("store-before-update test done");
        @(posedge clk_sys);
        srst <= 1'b1;
        @(posedge clk_sys);
        srst <= 1'b0;
        #1;
        check(dest_acc, Z40);
        check(dest_overflow_flag, 4'h0);
        check(store_data, Z16);
        $display("mid-run reset test done");
        give_verdict();
    end
endmodule
